// file: rtl/sfcrp_top.sv
`timescale 1ns/1ps
module sfcrp_top #(
	parameter int FIFO_DEPTH = sfcrp_pkg::FIFO_D // prefetch words
)(
	input  logic                         ref_clk,
	input  logic                         reset_n,
	input  logic                         spiClk,
	input  logic                         csN,
	input  logic                         siIn,
	output logic                         siOut,
	output logic                         siOeN,
	input  logic                         soIn,
	output logic                         soOut,
	output logic                         soOeN,
	output logic [sfcrp_pkg::ADDR_W-1:0] arrAddr,
	output logic                         arrReq,
	input  logic                         arrAck,
	input  logic [sfcrp_pkg::BYTE_W-1:0] arrData,
	output logic                         respReq,
	input  logic [sfcrp_pkg::BYTE_W-1:0] respData,
	output logic [sfcrp_pkg::BYTE_W-1:0] cmdOp,
	output logic [sfcrp_pkg::ADDR_W-1:0] cmdAddr,
	output logic                         cmdStart,
	output logic [sfcrp_pkg::BYTE_W-1:0] cmdByte,
	output logic                         cmdByteValid,
	output logic                         cmdEnd,
	output logic                         cmdAligned
);
	import sfcrp_pkg::*;

	// ****************************************
	// pin synchronisation
	// ****************************************
	logic [3:0]    syncQ;    // clk, cs, si, so levels
	logic [3:0]    syncRise; // rising edges
	logic [3:0]    syncFall; // falling edges
	logic          sckRise;  // host clock rose
	logic          sckFall;  // host clock fell
	logic          csS;      // chip select deasserted
	logic          csEnd;    // deassert moment

	sfcrp_sync #(.W(4), .RST(SYNC_RST)) u_sync (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.din     ({spiClk, csN, siIn, soIn}),
		.q       (syncQ),
		.rise    (syncRise),
		.fall    (syncFall)
	);

	assign sckRise = syncRise[3];
	assign sckFall = syncFall[3];
	assign csS     = syncQ[2];
	assign csEnd   = syncRise[2];

	// ****************************************
	// command framing
	// ****************************************
	sfcrp_phase_t phase;     // frame phase
	sfcrp_cmd_t   cmd;       // decoded opcode of frame
	sfcrp_cmd_t   dec;       // decode of byte in flight
	logic [2:0]   bitCnt;    // bit within byte
	logic [1:0]   byteIdx;   // byte within phase
	logic [7:0]   inSh;      // input shifter
	logic [7:0]   inByte;    // shifter with current bits
	logic [15:0]  addrSh;    // first two address bytes
	logic [23:0]  addrFull;  // whole host address
	logic         dualIn;    // two bits per clock in
	logic         byteDone;  // last bit of byte sampled
	logic         phaseEnd;  // last byte of phase
	logic         addrDone;  // address complete
	logic         arrStart;  // array read begins

	assign dualIn   = phase == PH_DATA && cmd.dir == DIR_DIN;
	assign inByte   = dualIn ? {inSh[5:0], syncQ[0], syncQ[1]}
		: {inSh[6:0], syncQ[1]};
	assign dec      = sfcrp_decode(inByte);
	assign byteDone = sckRise && bitCnt == (dualIn ? 3'h6 : 3'h7);
	assign addrFull = {addrSh, inByte};
	assign addrDone = byteDone && phase == PH_ADDR
		&& byteIdx == ADDR_LAST;
	assign phaseEnd = phase == PH_OPC ||
		(phase == PH_ADDR && byteIdx == ADDR_LAST) ||
		(phase == PH_DUMMY && byteIdx == cmd.dummy - 2'h1);
	assign arrStart = addrDone &&
		(cmd.dir == DIR_ARR || cmd.dir == DIR_DARR);

	// phase sequencing, cs high always returns to idle
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			phase <= PH_IDLE;
		else if (csS)
			phase <= PH_IDLE;
		else if (phase == PH_IDLE)
			phase <= PH_OPC;
		else if (byteDone)
		begin
			unique case (phase)
				// unsupported codes park until cs high
				PH_OPC:
					if (!dec.ok)
						phase <= PH_IGNORE;
					else if (dec.addr)
						phase <= PH_ADDR;
					else
						phase <= PH_DATA;
				// dummy count from the opcode map
				PH_ADDR:
					if (phaseEnd)
						phase <= (cmd.dummy != 2'h0) ? PH_DUMMY
							: PH_DATA;
				PH_DUMMY:
					if (phaseEnd)
						phase <= PH_DATA;
				PH_IDLE, PH_DATA, PH_IGNORE: ;
			endcase
		end
	end

	// bit and byte counters
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bitCnt  <= 3'h0;
			byteIdx <= 2'h0;
		end
		else if (csS || phase == PH_IDLE)
		begin
			bitCnt  <= 3'h0;
			byteIdx <= 2'h0;
		end
		else if (sckRise)
		begin
			// dual in and dual out move two bits per clock
			bitCnt <= bitCnt + ((dualIn || (phase == PH_DATA
				&& cmd.dir == DIR_DARR)) ? 3'h2 : 3'h1);
			if (byteDone)
				byteIdx <= phaseEnd ? 2'h0 : byteIdx + 2'h1;
		end
	end

	// input shifting and capture, MSB first
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			inSh   <= 8'h00;
			addrSh <= 16'h0000;
			cmd    <= '{ok: 1'b0, addr: 1'b0, dummy: 2'h0,
				dir: DIR_NONE};
		end
		else if (sckRise && phase != PH_IDLE)
		begin
			inSh <= inByte;
			if (byteDone && phase == PH_OPC)
				cmd <= dec;
			if (byteDone && phase == PH_ADDR)
				addrSh <= addrFull[15:0];
		end
	end

	// ****************************************
	// command report outputs
	// ****************************************
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cmdOp        <= 8'h00;
			cmdAddr      <= '0;
			cmdStart     <= 1'b0;
			cmdByte      <= 8'h00;
			cmdByteValid <= 1'b0;
			cmdEnd       <= 1'b0;
			cmdAligned   <= 1'b0;
		end
		else
		begin
			// start only once opcode and address are whole
			cmdStart <= byteDone && ((phase == PH_OPC && dec.ok
				&& !dec.addr) || addrDone);
			if (byteDone && phase == PH_OPC)
				cmdOp <= inByte;
			if (addrDone)
				cmdAddr <= addrFull[ADDR_W-1:0];
			// incoming data bytes of write commands
			cmdByteValid <= byteDone && phase == PH_DATA &&
				(cmd.dir == DIR_IN || cmd.dir == DIR_DIN);
			if (byteDone && phase == PH_DATA)
				cmdByte <= inByte;
			// frame end, with byte alignment for aborts
			cmdEnd     <= csEnd && phase != PH_IDLE;
			cmdAligned <= bitCnt == 3'h0;
		end
	end

	// ****************************************
	// array fetch and prefetch buffer
	// ****************************************
	sfcrp_stream_if #(.W(BYTE_W)) bufIf ();
	logic fetching; // prefetch engine active

	sfcrp_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_fifo (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.s       (bufIf)
	);

	assign arrReq       = fetching && bufIf.wReady;
	assign bufIf.wValid = arrReq && arrAck;
	assign bufIf.wData  = arrData;
	assign bufIf.flush  = csS || arrStart;

	// address counter, natural wrap past last location
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			fetching <= 1'b0;
			arrAddr  <= '0;
		end
		else if (csS)
			fetching <= 1'b0;
		else if (arrStart)
		begin
			fetching <= 1'b1;
			arrAddr  <= addrFull[ADDR_W-1:0];
		end
		else if (arrReq && arrAck)
			arrAddr <= arrAddr + 1'b1;
	end

	// ****************************************
	// serial output
	// ****************************************
	logic       outDir;  // frame returns data
	logic       arrDir;  // data from array buffer
	logic       dualOut; // two bits per clock out
	logic       loadNow; // falling edge needs new byte
	logic       drv;     // pins driven
	logic [7:0] srcByte; // next byte to send
	logic [7:0] outSh;   // output shifter
	logic [1:0] outCnt;  // beat within byte in dual mode, zero when a load is due

	assign arrDir  = cmd.dir == DIR_ARR || cmd.dir == DIR_DARR;
	assign outDir  = arrDir || cmd.dir == DIR_OUT;
	assign dualOut = cmd.dir == DIR_DARR;
	assign loadNow = sckFall && phase == PH_DATA && outDir
		&& outCnt == 2'h0 && !csS;
	assign srcByte = !arrDir ? respData
		: (bufIf.rValid ? bufIf.rData : UNDERRUN);
	assign bufIf.rReady = loadNow && arrDir;
	assign respReq      = loadNow && !arrDir;
	assign soOeN = !drv;
	assign siOeN = !(drv && dualOut);

	// output counter and drive flag
	logic [2:0] outIdx; // bits sent in byte, single line
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			drv    <= 1'b0;
			outCnt <= 2'h0;
			outIdx <= 3'h0;
		end
		else if (csS || phase != PH_DATA)
		begin
			drv    <= 1'b0;
			outCnt <= 2'h0;
			outIdx <= 3'h0;
		end
		else if (sckFall && outDir)
		begin
			drv <= 1'b1;
			if (dualOut)
				outCnt <= outCnt + 2'h1;
			else
			begin
				outIdx <= outIdx + 3'h1;
				outCnt <= (outIdx == 3'h7) ? 2'h0 : 2'h1;
			end
		end
	end

	// shift data on falling edge, MSB first
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			soOut <= 1'b0;
			siOut <= 1'b0;
			outSh <= 8'h00;
		end
		else if (loadNow)
		begin
			soOut <= srcByte[7];
			siOut <= srcByte[6];
			outSh <= dualOut ? {srcByte[5:0], 2'b00}
				: {srcByte[6:0], 1'b0};
		end
		else if (sckFall && drv && !csS)
		begin
			soOut <= outSh[7];
			siOut <= outSh[6];
			outSh <= dualOut ? {outSh[5:0], 2'b00}
				: {outSh[6:0], 1'b0};
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	cs_float_a: assert property (csS |=> soOeN)
		else $error("so driven after cs high");
	dual_float_a: assert property (csS |=> siOeN && soOeN)
		else $error("dual lines driven after cs high");
	si_input_a: assert property (
		phase != PH_DATA || cmd.dir != DIR_DARR |-> siOeN)
		else $error("si driven outside dual read");
	idle_float_a: assert property (phase != PH_DATA |=> soOeN)
		else $error("output driven outside data phase");
	bad_op_a: assert property (byteDone && phase == PH_OPC
		&& !dec.ok && !csS |=> phase == PH_IGNORE)
		else $error("unsupported opcode not ignored");
	addr_step_a: assert property (arrReq && arrAck && !csS
		&& !arrStart |=> arrAddr == $past(arrAddr) + 1'b1)
		else $error("address counter did not advance");
	addr_wrap_a: assert property (arrReq && arrAck && !csS
		&& !arrStart && arrAddr == '1 |=> arrAddr == '0)
		else $error("address did not wrap to zero");
	fall_only_a: assert property ($changed(soOut)
		|-> $past(sckFall))
		else $error("output changed off falling edge");
	two_dummy_a: assert property ($rose(phase == PH_DATA)
		&& cmdOp == OP_RD_2D |-> $past(byteIdx) == 2'h1)
		else $error("1Bh data before two dummy bytes");
	one_dummy_a: assert property ($rose(phase == PH_DATA)
		&& cmdOp == OP_RD_1D |-> $past(phase) == PH_DUMMY
		&& $past(byteIdx) == 2'h0)
		else $error("0Bh data not after one dummy byte");
	no_dummy_a: assert property ($rose(phase == PH_DATA)
		&& cmdOp == OP_RD_0D |-> $past(phase) == PH_ADDR)
		else $error("03h data not right after address");

	dual_read_c: cover property (drv && dualOut && sckFall);
	wrap_c: cover property (arrReq && arrAck && arrAddr == '1);
	ignore_c: cover property (phase == PH_IGNORE);
endmodule // sfcrp_top

// file: rtl/sfcrp_pkg.sv
// Operation
// - 1Bh read: address, two dummy, data
// - 0Bh read: address, one dummy, data
// - 03h read: address then data directly
// - address counter advances per read byte
// - single read: one bit per clock, MSB first
// - wrap to zero past last byte, no gap
// - CS high ends read, output floats
// - 3Bh dual read: address, one dummy
// - dual read: two bits per clock, MSB on SO
// - CS high ends dual read, both float
// - decode 02h and A2h program commands
// - decode erase, suspend and resume opcodes
// - decode write enable, protect, read protect
// - decode lockdown, freeze, read lockdown
// - decode OTP program and OTP read
// - decode status read and status writes
// - decode ID read, data out only
// - decode power-down, wake and reset
// - CS low, 8-bit opcode, MSB first
// - bad opcode or early CS: ignore, idle
// - 24-bit address, top four bits ignored
// - sample on rising, shift on falling edge
package sfcrp_pkg;
	localparam int         ADDR_W    = 20;    // array address bits
	localparam int         BYTE_W    = 8;     // serial byte
	localparam int         FIFO_D    = 16;    // prefetch words
	localparam logic [1:0] DUM_ONE   = 2'h1;  // one dummy byte
	localparam logic [1:0] DUM_TWO   = 2'h2;  // two dummy bytes
	localparam logic [1:0] ADDR_LAST = 2'h2;  // third address byte
	localparam logic [3:0] SYNC_RST  = 4'h4;  // pins idle, cs high
	localparam logic [7:0] UNDERRUN  = 8'hFF; // empty buffer byte
	localparam logic [7:0] OP_RD_2D  = 8'h1B;
	localparam logic [7:0] OP_RD_1D  = 8'h0B;
	localparam logic [7:0] OP_RD_0D  = 8'h03;
	localparam logic [7:0] OP_RD_DU  = 8'h3B;
	localparam logic [7:0] OP_ER_4K  = 8'h20;
	localparam logic [7:0] OP_ER_32K = 8'h52;
	localparam logic [7:0] OP_ER_64K = 8'hD8;
	localparam logic [7:0] OP_ER_CA  = 8'h60;
	localparam logic [7:0] OP_ER_CB  = 8'hC7;
	localparam logic [7:0] OP_PP     = 8'h02;
	localparam logic [7:0] OP_PP_DU  = 8'hA2;
	localparam logic [7:0] OP_SUSP   = 8'hB0;
	localparam logic [7:0] OP_RESUME = 8'hD0;
	localparam logic [7:0] OP_WREN   = 8'h06;
	localparam logic [7:0] OP_WRDIS  = 8'h04;
	localparam logic [7:0] OP_PROT   = 8'h36;
	localparam logic [7:0] OP_UNPROT = 8'h39;
	localparam logic [7:0] OP_RDPROT = 8'h3C;
	localparam logic [7:0] OP_LOCK   = 8'h33;
	localparam logic [7:0] OP_FREEZE = 8'h34;
	localparam logic [7:0] OP_RDLOCK = 8'h35;
	localparam logic [7:0] OP_OTP_PG = 8'h9B;
	localparam logic [7:0] OP_OTP_RD = 8'h77;
	localparam logic [7:0] OP_RDSTAT = 8'h05;
	localparam logic [7:0] OP_WRST1  = 8'h01;
	localparam logic [7:0] OP_WRST2  = 8'h31;
	localparam logic [7:0] OP_RESET  = 8'hF0;
	localparam logic [7:0] OP_ID     = 8'h9F;
	localparam logic [7:0] OP_SLEEP  = 8'hB9;
	localparam logic [7:0] OP_WAKE   = 8'hAB;

	// frame phase, gray along idle-opcode-address-dummy-data
	typedef enum logic [2:0] {
		PH_IDLE = 3'h0, PH_OPC = 3'h1, PH_ADDR = 3'h3,
		PH_DUMMY = 3'h2, PH_DATA = 3'h6, PH_IGNORE = 3'h7
	} sfcrp_phase_t;

	// data phase kind
	typedef enum logic [2:0] {
		DIR_NONE, DIR_IN, DIR_DIN, DIR_OUT, DIR_ARR, DIR_DARR
	} sfcrp_dir_t;

	typedef struct packed {
		logic       ok;    // supported opcode
		logic       addr;  // three address bytes follow
		logic [1:0] dummy; // dummy byte count
		sfcrp_dir_t dir;
	} sfcrp_cmd_t;

	// opcode map
	function automatic sfcrp_cmd_t sfcrp_decode(input logic [7:0] op);
		sfcrp_cmd_t c;
		c = '{ok: 1'b1, addr: 1'b1, dummy: 2'h0, dir: DIR_NONE};
		case (op)
			OP_RD_2D:  begin c.dummy = DUM_TWO; c.dir = DIR_ARR; end
			OP_RD_1D:  begin c.dummy = DUM_ONE; c.dir = DIR_ARR; end
			OP_RD_0D:  c.dir = DIR_ARR;
			OP_RD_DU:  begin c.dummy = DUM_ONE; c.dir = DIR_DARR; end
			OP_ER_4K, OP_ER_32K, OP_ER_64K, OP_PROT, OP_UNPROT: ;
			OP_ER_CA, OP_ER_CB, OP_SUSP, OP_RESUME, OP_WREN,
			OP_WRDIS, OP_SLEEP, OP_WAKE: c.addr = 1'b0;
			OP_PP, OP_LOCK, OP_FREEZE, OP_OTP_PG: c.dir = DIR_IN;
			OP_PP_DU:  c.dir = DIR_DIN;
			OP_RDPROT, OP_RDLOCK: c.dir = DIR_OUT;
			OP_OTP_RD: begin c.dummy = DUM_TWO; c.dir = DIR_OUT; end
			OP_RDSTAT, OP_ID: begin c.addr = 1'b0; c.dir = DIR_OUT; end
			OP_WRST1, OP_WRST2, OP_RESET:
			begin
				c.addr = 1'b0;
				c.dir = DIR_IN;
			end
			default:   c.ok = 1'b0;
		endcase
		return c;
	endfunction
endpackage

// file: rtl/sfcrp_stream_if.sv
`timescale 1ns/1ps
interface sfcrp_stream_if #(parameter int W = 8);
	logic [W-1:0] wData;  // word into buffer
	logic         wValid; // word offered
	logic         wReady; // buffer has room
	logic [W-1:0] rData;  // oldest word
	logic         rValid; // buffer not empty
	logic         rReady; // consumer takes word
	logic         flush;  // drop all contents
	modport fifo (input wData, wValid, rReady, flush,
		output wReady, rData, rValid);
	modport user (output wData, wValid, rReady, flush,
		input wReady, rData, rValid);
endinterface // sfcrp_stream_if

// file: rtl/sfcrp_sync.sv
`timescale 1ns/1ps
module sfcrp_sync #(
	parameter int             W   = 1,
	parameter logic [W-1:0]   RST = '0
)(
	input  logic         ref_clk,
	input  logic         reset_n,
	input  logic [W-1:0] din,
	output logic [W-1:0] q,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	logic [W-1:0] meta; // first stage, read by q only
	logic [W-1:0] last; // previous q for edges

	// two-stage synchroniser plus edge history
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta <= RST;
			q    <= RST;
			last <= RST;
		end
		else
		begin
			meta <= din;
			q    <= meta;
			last <= q;
		end
	end

	assign rise = q & ~last;
	assign fall = ~q & last;
endmodule // sfcrp_sync

// file: rtl/sfcrp_fifo.sv
`timescale 1ns/1ps
module sfcrp_fifo #(
	parameter int W = 8,
	parameter int D = 16
)(
	input logic         ref_clk,
	input logic         reset_n,
	sfcrp_stream_if.fifo s
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D]; // storage, D a power of two
	logic [AW:0]  wPtr;    // write pointer, wrap bit on top
	logic [AW:0]  rPtr;    // read pointer
	logic         push;
	logic         pop;

	assign s.rValid = wPtr != rPtr;
	assign s.wReady = (wPtr[AW] == rPtr[AW]) ||
		(wPtr[AW-1:0] != rPtr[AW-1:0]);
	assign s.rData  = mem[rPtr[AW-1:0]];
	assign push     = s.wValid && s.wReady && !s.flush;
	assign pop      = s.rValid && s.rReady && !s.flush;

	// storage write
	always_ff @(posedge ref_clk)
		if (push)
			mem[wPtr[AW-1:0]] <= s.wData;

	// pointers, flush empties
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wPtr <= '0;
			rPtr <= '0;
		end
		else if (s.flush)
		begin
			wPtr <= '0;
			rPtr <= '0;
		end
		else
		begin
			if (push)
				wPtr <= wPtr + 1'b1;
			if (pop)
				rPtr <= rPtr + 1'b1;
		end
	end
endmodule // sfcrp_fifo

// file: dv/sfcrp_host.sv
`timescale 1ns/1ps
// ************************************
// spi host model, mode 0 or 3, 5 MHz link
// ************************************
module sfcrp_host (
	input  logic ref_clk, // phase reference only
	output logic spiClk,  // stands at idle level outside frames
	output logic csN,     // select, active low
	output logic siDrv,   // host side of si
	output logic soDrv,   // host side of so
	input  logic siPin,   // resolved si level
	input  logic soPin    // resolved so level
);
	logic idleHi = 1'b0; // clock level between frames, 1 for mode 3

	// idle bus at time zero
	initial
	begin
		spiClk = 1'b0;
		csN    = 1'b1;
		siDrv  = 1'b0;
		soDrv  = 1'b0;
	end

	// select, kept clear of the core clock edge
	task automatic start();
		spiClk = idleHi;
		@(posedge ref_clk);
		#7;
		csN = 1'b0;
		#100;
	endtask

	// nb beats; md 0 single, 1 dual out, 2 dual in
	task automatic xfer(input logic [7:0] tx, input int md, input int nb,
		output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 0; i < nb; i++)
		begin
			spiClk = 1'b0;
			// released lines flip every beat
			if (md == 2)
			begin
				soDrv = tx[7-2*i];
				siDrv = tx[6-2*i];
			end
			else
			begin
				soDrv = ~soDrv;
				siDrv = (md == 1) ? ~siDrv : tx[7-i];
			end
			#100;
			spiClk = 1'b1;
			#95;
			// late sample, device output settled
			rx = (md == 1) ? {rx[5:0], soPin, siPin} : {rx[6:0], soPin};
			#5;
		end
	endtask

	// clock to idle level, then deselect
	task automatic stop();
		spiClk = idleHi;
		siDrv  = ~siDrv;
		#100;
		csN = 1'b1;
		#250;
	endtask
endmodule // sfcrp_host

// file: dv/spi_flash_command_read_path_test.sv
`timescale 1ns/1ps
module spi_flash_command_read_path_test;
	import sfcrp_pkg::*;
	// ********************
	// signals
	// ********************
	logic                ref_clk = 1'b0;
	logic                reset_n = 1'b0;
	logic                spiClk, csN, siIn, siOut, siOeN, soIn, soOut;
	logic                soOeN, siDrv, soDrv, arrReq, respReq, cmdStart;
	logic                cmdByteValid, cmdEnd, cmdAligned;
	logic                arrAck = 1'b0;
	logic [ADDR_W-1:0]   arrAddr, cmdAddr, lastAddr;
	logic [BYTE_W-1:0]   arrData, cmdOp, cmdByte, lastOp;
	logic [BYTE_W-1:0]   respData = 8'h00;
	logic                fast = 1'b0;    // array answers every cycle
	logic                lastAligned;    // byte boundary at last end
	logic [7:0]          rxQ[$], respQ[$];
	int                  n_mismatch, comparisons, cyc, nStart;
	// command table: opcode, address, two dummies, kind
	localparam logic [11:0] CMDS [26] = '{{OP_ER_4K, 4'h8},
		{OP_ER_32K, 4'h8}, {OP_ER_64K, 4'h8}, {OP_ER_CA, 4'h0},
		{OP_ER_CB, 4'h0}, {OP_SUSP, 4'h0}, {OP_RESUME, 4'h0},
		{OP_WREN, 4'h0}, {OP_WRDIS, 4'h0}, {OP_PROT, 4'h8},
		{OP_UNPROT, 4'h8}, {OP_RDPROT, 4'hA}, {OP_LOCK, 4'h9},
		{OP_FREEZE, 4'h9}, {OP_RDLOCK, 4'hA}, {OP_OTP_PG, 4'h9},
		{OP_OTP_RD, 4'hE}, {OP_RDSTAT, 4'h2}, {OP_WRST1, 4'h1},
		{OP_WRST2, 4'h1}, {OP_RESET, 4'h1}, {OP_ID, 4'h2},
		{OP_SLEEP, 4'h0}, {OP_WAKE, 4'h0}, {OP_PP, 4'h9},
		{OP_PP_DU, 4'h9}};

	// ********************
	// clock, pins, array
	// ********************
	always #12.5 ref_clk = ~ref_clk;
	// pin level from the device's output enables
	assign siIn = siOeN ? siDrv : siOut;
	assign soIn = soOeN ? soDrv : soOut;
	assign arrData = memByte(arrAddr);

	// array content pattern
	function automatic logic [7:0] memByte(input logic [19:0] a);
		return a[7:0] ^ a[19:12] ^ 8'h5A;
	endfunction

	sfcrp_host host (.ref_clk(ref_clk), .spiClk(spiClk), .csN(csN),
		.siDrv(siDrv), .soDrv(soDrv), .siPin(siIn), .soPin(soIn));

	sfcrp_top #(.FIFO_DEPTH(16)) dut (.ref_clk(ref_clk),
		.reset_n(reset_n), .spiClk(spiClk), .csN(csN), .siIn(siIn),
		.siOut(siOut), .siOeN(siOeN), .soIn(soIn), .soOut(soOut),
		.soOeN(soOeN), .arrAddr(arrAddr), .arrReq(arrReq),
		.arrAck(arrAck), .arrData(arrData), .respReq(respReq),
		.respData(respData), .cmdOp(cmdOp), .cmdAddr(cmdAddr),
		.cmdStart(cmdStart), .cmdByte(cmdByte),
		.cmdByteValid(cmdByteValid), .cmdEnd(cmdEnd),
		.cmdAligned(cmdAligned));

	// random stalls, response bytes, monitor, watchdog
	always @(posedge ref_clk)
	begin
		arrAck   <= fast | ($urandom_range(3) != 0);
		respData <= 8'($urandom);
		if (cmdStart)
		begin
			nStart   <= nStart + 1;
			lastOp   <= cmdOp;
			lastAddr <= cmdAddr;
		end
		if (cmdByteValid) rxQ.push_back(cmdByte);
		if (respReq) respQ.push_back(respData);
		if (cmdEnd) lastAligned <= cmdAligned;
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			n_mismatch++;
			print_verdict();
		end
	end

	// ********************
	// tasks
	// ********************
	task automatic check(input string what, input logic [23:0] exp,
		input logic [23:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// opcode, address, dummies
	task automatic rd(input logic [7:0] op, input logic [23:0] a,
		input int nd);
		logic [7:0] rx;
		host.start();
		host.xfer(op, 0, 8, rx);
		for (int i = 2; i >= 0; i--) host.xfer(a[8*i+:8], 0, 8, rx);
		for (int i = 0; i < nd; i++) host.xfer(8'($urandom), 0, 8, rx);
		check("si enable", 1'b1, siOeN);
	endtask

	// n data bytes from offset k0
	task automatic data(input logic [23:0] a, input int k0, input int n,
		input int md);
		logic [7:0] rx;
		for (int k = k0; k < k0 + n; k++)
		begin
			host.xfer(8'h00, md, md ? 4 : 8, rx);
			check("rdata", memByte(20'(a[19:0] + k)), rx);
		end
		check("cmdAddr", a[19:0], lastAddr);
	endtask

	// deselect, both lines released
	task automatic finish_frame(input logic aligned);
		host.stop();
		check("so enable", 1'b1, soOeN);
		check("si enable", 1'b1, siOeN);
		check("aligned", aligned, lastAligned);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ********************
	// main sequence
	// ********************
	initial
	begin : main
		logic [23:0] a;
		logic [11:0] e;
		logic [7:0]  rx, b;
		logic [7:0]  ops [3];
		int          n0, md;
		ops = '{OP_RD_0D, OP_RD_1D, OP_RD_2D};
		void'($urandom(32'hE70E));
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (10) @(posedge ref_clk);
		// three single reads, dummies 0..2
		for (int i = 0; i < 3; i++)
		begin
			a = 24'($urandom);
			fast = (i == 0);
			host.idleHi = (i == 2);
			rd(ops[i], a, i);
			data(a, 0, 3, 0);
			finish_frame(1'b1);
		end
		fast = 1'b0;
		host.idleHi = 1'b0;
		$display("test reads done");
		// wrap, then host stalls with buffer full
		a = 24'hAFFFFE;
		rd(OP_RD_1D, a, 1);
		data(a, 0, 3, 0);
		repeat (600) @(posedge ref_clk);
		check("arrReq full", 1'b0, arrReq);
		data(a, 3, 18, 0);
		finish_frame(1'b1);
		$display("test wrap and stall done");
		// dual read across the array end
		a = 24'h3FFFFD;
		rd(OP_RD_DU, a, 1);
		data(a, 0, 5, 1);
		finish_frame(1'b1);
		$display("test dual read done");
		// deselect inside a byte, single and dual
		for (md = 0; md < 2; md++)
		begin
			a = 24'($urandom);
			rd(md ? OP_RD_DU : OP_RD_1D, a, 1);
			host.xfer(8'h00, md, md ? 1 : 3, rx);
			finish_frame(1'b0);
		end
		$display("test partial done");
		// unknown opcodes and early deselect start nothing
		for (int j = 0; j < 3; j++)
		begin
			n0 = nStart;
			host.start();
			host.xfer((j == 0) ? 8'hFF : (j == 1) ? 8'h00 : OP_RD_1D, 0, 8, rx);
			for (int i = 0; i < ((j == 2) ? 2 : 4); i++)
				host.xfer(8'($urandom), 0, 8, rx);
			check("so enable", 1'b1, soOeN);
			host.stop();
			check("starts", 24'(n0), 24'(nStart));
		end
		$display("test ignored frames done");
		// opcode map apart from the four reads
		for (int j = 0; j < 26; j++)
		begin
			e = CMDS[j];
			n0 = nStart;
			b = 8'($urandom);
			md = (e[11:4] == OP_PP_DU) ? 2 : 0;
			rxQ.delete();
			respQ.delete();
			host.start();
			host.xfer(e[11:4], 0, 8, rx);
			for (int i = 0; i < (e[3] ? 3 : 0) + (e[2] ? 2 : 0); i++)
				host.xfer(8'($urandom), 0, 8, rx);
			if (e[1:0] == 2'h1) host.xfer(b, md, md ? 4 : 8, rx);
			if (e[1:0] == 2'h2) host.xfer(8'h00, 0, 8, rx);
			host.stop();
			check("starts", 24'(n0 + 1), 24'(nStart));
			check("opcode", e[11:4], lastOp);
			if (e[1:0] == 2'h1)
				check("cmdByte", b, rxQ[0]);
			if (e[1:0] == 2'h2)
				check("resp byte", respQ[0], rx);
		end
		$display("test opcode map done");
		print_verdict();
	end
endmodule // spi_flash_command_read_path_test
